// *** verilog/eps_top.sv ***
// Purpose: position output with preset/offset and scaling, expedited object
//          writes/reads with confirmation, and millisecond-paced cyclic position frames
// Assumes: frames arrive from a controller on the same clock; raw position is
//          a physical count from same-clock logic
// Notes:   transmitted frames pass a FIFO; rx is stalled while an answer waits
// Operation
// - accepted write answered on 580h+node with 60h, index, subindex, zero data.
// - multi-byte data fields carry least significant byte first.
// - custom total below custom steps per revolution raises an error; res_err_o only with scaling (bit 2) on.
// - output equals read position plus preset minus offset.
// - executing preset stores current position as offset.
// - preset applies to position held when the preset write arrives.
// - preset and offset reset to zero; output then equals read position.
// - with scaling enabled the position is scaled by custom parameters.
// - position sent cyclically or synchronously per first transmit parameter sets; only cyclic (type FEh) sending is built here, no synchronous.
// - type FEh with nonzero timer sends position frame every timer interval.
// - timer zero means no cyclic position frame.
// - cyclic timer is 16-bit read-write milliseconds, reset zero.
// - operating parameter bit 2 selects hardware or custom resolution.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module eps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  wire              push = in_valid_i && in_ready_o;
  // output stage refills when empty or being drained
  wire              pop  = (count_ff != '0) && (!out_valid_ff || out_ready_i);
  wire              full = (count_ff == (AW+1)'(DEPTH));

  assign in_ready_o  = !full;
  assign out_valid_o = out_valid_ff;
  assign out_data_o  = out_data_ff;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      count_ff  <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        out_valid_ff <= 1'b1;
        out_data_ff  <= mem[rd_ptr_ff];
      end else if (out_ready_i) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module eps_top #(
  parameter int unsigned CYC_PER_MS_P = eps_pkg::CYC_PER_MS,
  parameter int unsigned HW_CPR_LOG2  = 13,
  parameter logic [31:0] HW_TOTAL     = 32'h0200_0000,
  parameter int unsigned FIFO_DEPTH   = 32
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic [eps_pkg::NODE_W-1:0]  node_id_i,
  input  wire logic                        rx_valid_i,
  output logic                             rx_ready_o,
  input  wire logic [eps_pkg::ID_W-1:0]    rx_id_i,
  input  wire logic [eps_pkg::DATA_W-1:0]  rx_data_i,
  output logic                             tx_valid_o,
  input  wire logic                        tx_ready_i,
  output logic      [eps_pkg::ID_W-1:0]    tx_id_o,
  output logic      [eps_pkg::DLC_W-1:0]   tx_dlc_o,
  output logic      [eps_pkg::DATA_W-1:0]  tx_data_o,
  input  wire logic [15:0]                 op_param_i,
  input  wire logic [31:0]                 custom_steps_i,
  input  wire logic [31:0]                 custom_total_i,
  input  wire logic [31:0]                 pos_raw_i,
  input  wire logic [7:0]                  tx_type_i,
  input  wire logic                        operational_i,
  output logic      [31:0]                 position_o,
  output logic                             res_err_o
);
  import eps_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // request decode
  logic                rx_ready_ff;
  logic                resp_pend_ff;
  logic [FRAME_W-1:0]  resp_ff;
  logic [31:0]         preset_ff;
  logic [31:0]         offset_ff;
  logic [31:0]         pos_read_ff;
  logic [31:0]         total_ff;
  logic [31:0]         position_ff;
  logic                res_err_ff;
  logic [15:0]         cyc_ff;
  logic [15:0]         iv_cnt_ff;
  logic [31:0]         ms_cnt_ff;
  logic                pdo_pend_ff;

  wire [ID_W-1:0] sdo_rx_id = SDO_RX_BASE + {4'h0, node_id_i};
  wire [ID_W-1:0] sdo_tx_id = SDO_TX_BASE + {4'h0, node_id_i};
  wire [ID_W-1:0] pdo_tx_id = PDO1_TX_BASE + {4'h0, node_id_i};
  wire [7:0]  rx_cmd   = rx_data_i[CMD_LSB +: 8];
  wire [15:0] rx_idx   = {rx_data_i[IDX_HI_LSB +: 8], rx_data_i[IDX_LO_LSB +: 8]};
  wire [7:0]  rx_sub   = rx_data_i[SUB_LSB +: 8];
  wire [31:0] rx_val32 = rx_data_i[VAL_LSB +: 32];
  // 16-bit value in first two bytes
  wire [15:0] rx_val16 = rx_data_i[VAL_LSB +: 16];
  wire rx_take   = rx_valid_i && rx_ready_ff && (rx_id_i == sdo_rx_id) && (rx_sub == SUB_0);
  wire wr_preset = rx_take && (rx_cmd == CMD_WR32) && (rx_idx == IDX_PRESET);
  wire wr_cyc    = rx_take && (rx_cmd == CMD_WR16) && (rx_idx == IDX_CYCLIC);
  wire rd_cmd    = rx_take && (rx_cmd == CMD_RD);
  wire rd_preset = rd_cmd && (rx_idx == IDX_PRESET);
  wire rd_pos    = rd_cmd && (rx_idx == IDX_POSITION);
  wire rd_cyc    = rd_cmd && (rx_idx == IDX_CYCLIC);
  wire answered  = wr_preset || wr_cyc || rd_preset || rd_pos || rd_cyc;

  wire [31:0] rd_value = rd_preset ? preset_ff :
                         rd_pos    ? position_ff :
                         rd_cyc    ? {16'h0000, cyc_ff} : 32'h0000_0000;
  wire [7:0]  ans_cmd  = rd_cyc ? CMD_RD_ANS16 : (rd_cmd ? CMD_RD_ANS32 : CMD_WR_ACK);
  // echo index/subindex, value little-endian (zero for a write)
  wire [DATA_W-1:0] ans_data = {rd_value, rx_sub, rx_idx[15:8], rx_idx[7:0], ans_cmd};

  //////////////////////////////////////////////////////////////////////////////
  // transmit arbitration: answers first, then the cyclic position frame
  logic fifo_in_ready;
  wire  resp_push     = resp_pend_ff && fifo_in_ready;
  wire  pdo_push      = !resp_pend_ff && pdo_pend_ff && fifo_in_ready;
  wire  fifo_in_valid = resp_pend_ff || pdo_pend_ff;
  wire [FRAME_W-1:0] pdo_frame = {pdo_tx_id, DLC_POS, 32'h0000_0000, position_ff};
  wire [FRAME_W-1:0] fifo_in_data = resp_pend_ff ? resp_ff : pdo_frame;
  wire  nxt_resp_pend = answered || (resp_pend_ff && !resp_push);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      resp_pend_ff <= 1'b0;
      rx_ready_ff  <= 1'b0;
      resp_ff      <= '0;
    end else begin
      resp_pend_ff <= nxt_resp_pend;
      // one answer in flight: refuse new frames until it is queued
      rx_ready_ff  <= !nxt_resp_pend;
      resp_ff      <= answered ? {sdo_tx_id, DLC_FULL, ans_data} : resp_ff;
    end
  end
  assign rx_ready_o = rx_ready_ff;

  //////////////////////////////////////////////////////////////////////////////
  // position path
  // resolution source select
  wire        scale_on  = op_param_i[OPPAR_SCALE_BIT];
  wire [31:0] total_act = scale_on ? custom_total_i : HW_TOTAL;
  // custom steps over hardware steps per revolution (hardware steps a power of two)
  wire [63:0] scale_prod = {32'h0, pos_raw_i} * {32'h0, custom_steps_i};
  wire [63:0] scale_shr  = scale_prod >> HW_CPR_LOG2;
  wire [31:0] read_src   = scale_on ? scale_shr[31:0] : pos_raw_i;
  // single fold only: assumes the source stays below twice the total
  wire [31:0] read_wrap  = (read_src >= total_act) ? read_src - total_act : read_src;
  // read + preset - offset, sign kept in bit 33
  wire [33:0] pos_sum = {2'b00, pos_read_ff} + {2'b00, preset_ff} - {2'b00, offset_ff};
  // fold into 0..total-1 with the total that pos_read_ff was folded by, so a total change stays consistent
  wire [33:0] pos_fold = pos_sum[33] ? pos_sum + {2'b00, total_ff} :
                         (pos_sum >= {2'b00, total_ff}) ? pos_sum - {2'b00, total_ff} : pos_sum;
  // custom total below steps per revolution
  wire nxt_res_err = scale_on && (custom_total_i < custom_steps_i);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      preset_ff   <= PRESET_RST;
      offset_ff   <= OFFSET_RST;
      pos_read_ff <= '0;
      total_ff    <= HW_TOTAL;
      position_ff <= '0;
      res_err_ff  <= 1'b0;
    end else begin
      pos_read_ff <= read_wrap;
      total_ff    <= total_act;
      position_ff <= pos_fold[31:0];
      res_err_ff  <= nxt_res_err;
      // capture the position held when the write arrives
      if (wr_preset) begin
        preset_ff <= rx_val32;
        offset_ff <= pos_read_ff;
      end
    end
  end
  assign position_o = position_ff;
  assign res_err_o  = res_err_ff;

  //////////////////////////////////////////////////////////////////////////////
  // cyclic transmission timer
  // asynchronous type with nonzero period while operational
  wire cyc_on  = (tx_type_i == TXTYPE_ASYNC) && (cyc_ff != CYCLIC_RST) && operational_i;
  wire ms_tick = (ms_cnt_ff == 32'(CYC_PER_MS_P - 1));
  wire pdo_due = cyc_on && ms_tick && (iv_cnt_ff <= 16'h0001);
  // a pending frame is dropped as soon as transmission stops
  wire nxt_pdo_pend = cyc_on && (pdo_due || (pdo_pend_ff && !pdo_push));

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_ff      <= CYCLIC_RST;
      iv_cnt_ff   <= CYCLIC_RST;
      ms_cnt_ff   <= '0;
      pdo_pend_ff <= 1'b0;
    end else begin
      pdo_pend_ff <= nxt_pdo_pend;
      cyc_ff      <= wr_cyc ? rx_val16 : cyc_ff;
      // reload on write or while inactive, restart when each frame falls due
      if (wr_cyc) begin
        iv_cnt_ff <= rx_val16;
        ms_cnt_ff <= '0;
      end else if (!cyc_on) begin
        iv_cnt_ff <= cyc_ff;
        ms_cnt_ff <= '0;
      end else if (ms_tick) begin
        ms_cnt_ff <= '0;
        iv_cnt_ff <= pdo_due ? cyc_ff : iv_cnt_ff - 16'h0001;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outgoing frame queue; a stalled controller backs up to rx_ready_o
  logic [FRAME_W-1:0] fifo_out_data;
  eps_fifo #(
    .WIDTH (FRAME_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (fifo_out_data)
  );
  assign tx_id_o   = fifo_out_data[FRAME_W-1 -: ID_W];
  assign tx_dlc_o  = fifo_out_data[DATA_W +: DLC_W];
  assign tx_data_o = fifo_out_data[DATA_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_WR_ACK: assert property ((wr_preset || wr_cyc) |=> resp_pend_ff
    && resp_ff[FRAME_W-1 -: ID_W] == $past(sdo_tx_id) && resp_ff[7:0] == CMD_WR_ACK
    && resp_ff[63:32] == 32'h0000_0000)
    else $error("write confirmation malformed");
  AST_RD_LE: assert property (rd_pos |=> resp_ff[39:32] == $past(position_ff[7:0])
    && resp_ff[63:56] == $past(position_ff[31:24]))
    else $error("read answer not little-endian");
  AST_RES_ERR: assert property (nxt_res_err |=> res_err_o)
    else $error("resolution error not flagged");
  AST_PRESET_HIT: assert property ((wr_preset && rx_val32 < total_act) ##1
    ($stable(pos_read_ff) && $stable(total_act)) |=> position_o == $past(preset_ff))
    else $error("preset not applied at capture position");
  AST_OFFSET_CAP: assert property (wr_preset |=> offset_ff == $past(pos_read_ff))
    else $error("offset not taken from current position");
  AST_PASS_THRU: assert property ((preset_ff == '0 && offset_ff == '0)
    |=> position_o == $past(pos_read_ff))
    else $error("output differs from read position without preset");
  AST_HW_SRC: assert property ((!scale_on && pos_raw_i < HW_TOTAL)
    |=> pos_read_ff == $past(pos_raw_i))
    else $error("hardware resolution source not used");
  AST_WRAP: assert property (($past(total_act, 2) == total_act && $past(total_act) == total_act
    && $past(preset_ff) < total_act) |-> position_o < total_act)
    else $error("position outside total resolution");
  AST_TIMER_OFF: assert property ((cyc_ff == CYCLIC_RST) |=> !pdo_pend_ff)
    else $error("cyclic frame pending with zero timer");
  AST_DUE_SET: assert property (pdo_due |=> pdo_pend_ff ##0 iv_cnt_ff == $past(cyc_ff))
    else $error("cyclic frame not raised at interval end");
  AST_RELOAD: assert property (wr_cyc |=> iv_cnt_ff == $past(rx_val16) && ms_cnt_ff == '0)
    else $error("interval counter not reloaded on write");
  AST_RX_HOLD: assert property (answered |=> !rx_ready_o)
    else $error("request accepted while an answer is pending");
  AST_IDX_ECHO: assert property (answered |=> resp_ff[23:8] == $past(rx_idx) && resp_ff[31:24] == SUB_0)
    else $error("answer index or subindex not echoed");
  AST_RD_TIMER: assert property (rd_cyc |=> resp_ff[7:0] == CMD_RD_ANS16
    && resp_ff[47:32] == $past(cyc_ff) && resp_ff[63:48] == 16'h0000)
    else $error("timer read answer malformed");
  AST_TX_HOLD: assert property ((tx_valid_o && !tx_ready_i) |=> tx_valid_o
    && $stable(tx_id_o) && $stable(tx_data_o) && $stable(tx_dlc_o))
    else $error("outgoing frame changed before it was taken");
  AST_ERR_CLR: assert property (!nxt_res_err |=> !res_err_o)
    else $error("resolution error flag stuck");
  AST_PRESET_HOLD: assert property (!wr_preset |=> $stable(preset_ff) && $stable(offset_ff))
    else $error("preset or offset changed without a preset write");
  AST_TIMER_WR: assert property (wr_cyc |=> cyc_ff == $past(rx_val16))
    else $error("cyclic period not stored");
  AST_TIMER_HOLD: assert property (!wr_cyc |=> $stable(cyc_ff))
    else $error("cyclic period changed without a write");
  AST_INACTIVE: assert property (!cyc_on |=> !pdo_pend_ff)
    else $error("cyclic frame pending while transmission inactive");
  AST_IV_STEP: assert property ((cyc_on && ms_tick && !pdo_due && !wr_cyc)
    |=> iv_cnt_ff == $past(iv_cnt_ff) - 16'h0001)
    else $error("interval counter did not step on the millisecond tick");
  AST_MS_RUN: assert property ((cyc_on && !ms_tick && !wr_cyc)
    |=> ms_cnt_ff == $past(ms_cnt_ff) + 32'h0000_0001)
    else $error("millisecond prescaler did not advance");
endmodule

// *** common/eps_pkg.sv ***
// Purpose: shared constants of the encoder position / preset / cyclic tx block
// Assumes: 11-bit frame identifiers, 8 data bytes per frame, byte 0 in bits 7:0
// Notes:   frame word layout is {id, dlc, data}
package eps_pkg;
  localparam int unsigned ID_W      = 11;
  localparam int unsigned DLC_W     = 4;
  localparam int unsigned DATA_W    = 64;
  localparam int unsigned FRAME_W   = ID_W + DLC_W + DATA_W;
  localparam int unsigned NODE_W    = 7;

  localparam logic [10:0] SDO_RX_BASE  = 11'h600;
  localparam logic [10:0] SDO_TX_BASE  = 11'h580;
  localparam logic [10:0] PDO1_TX_BASE = 11'h180;

  localparam logic [7:0]  CMD_WR32     = 8'h23;
  localparam logic [7:0]  CMD_WR16     = 8'h2B;
  localparam logic [7:0]  CMD_WR_ACK   = 8'h60;
  localparam logic [7:0]  CMD_RD       = 8'h40;
  localparam logic [7:0]  CMD_RD_ANS32 = 8'h43;
  localparam logic [7:0]  CMD_RD_ANS16 = 8'h4B;
  localparam logic [7:0]  SUB_0        = 8'h00;

  localparam logic [15:0] IDX_PRESET   = 16'h6003;
  localparam logic [15:0] IDX_POSITION = 16'h6004;
  localparam logic [15:0] IDX_CYCLIC   = 16'h6200;

  localparam logic [31:0] PRESET_RST   = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RST   = 32'h0000_0000;
  localparam logic [15:0] CYCLIC_RST   = 16'h0000;
  localparam logic [7:0]  TXTYPE_ASYNC = 8'hFE;
  localparam int unsigned OPPAR_SCALE_BIT = 2;

  localparam logic [3:0]  DLC_FULL     = 4'h8;
  localparam logic [3:0]  DLC_POS      = 4'h4;

  // byte lanes of a frame's data field
  localparam int unsigned CMD_LSB      = 0;
  localparam int unsigned IDX_LO_LSB   = 8;
  localparam int unsigned IDX_HI_LSB   = 16;
  localparam int unsigned SUB_LSB      = 24;
  localparam int unsigned VAL_LSB      = 32;

  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
endpackage

// *** bench/eps_master.sv ***
// Purpose: network master model issuing object requests and taking frames
// Assumes: one request outstanding at a time; node number static
// Notes:   released request lines show the inverse of the last frame
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module eps_master (
  input  wire logic        clk_sys_i,
  input  wire logic [6:0]  node_id_i,
  input  wire logic        rx_ready_i,
  input  wire logic        stall_i,
  output logic             rx_valid_o,
  output logic      [10:0] rx_id_o,
  output logic      [63:0] rx_data_o,
  output logic             tx_ready_o
);
  import eps_pkg::*;
  // a slow master simply holds off acceptance
  assign tx_ready_o = !stall_i;
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o    = 11'h000;
    rx_data_o  = 64'h0;
  end
  // expedited request, index and value low byte first
  task automatic send(input logic [7:0] cmd, input logic [15:0] idx, input logic [31:0] val,
                      input int lim, output bit ok);
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b1;
    rx_id_o    <= SDO_RX_BASE + 11'(node_id_i);
    rx_data_o  <= {val, SUB_0, idx, cmd};
    wait_take(lim, ok);
  endtask
  // request held until the edge that takes it
  task automatic wait_take(input int lim, output bit ok);
    int n;
    n  = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(posedge clk_sys_i);
      ok = (rx_ready_i === 1'b1);
      n++;
    end
    if (ok) begin
      rx_valid_o <= 1'b0;
      rx_id_o    <= ~rx_id_o;
      rx_data_o  <= ~rx_data_o;
    end
  endtask
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for position, preset and cyclic frames
// Assumes: millisecond shortened to 4 clock cycles
// Notes:   expected answers queue per request; a watcher pops them as frames leave
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module tb;
  import eps_pkg::*;
  localparam int CPM = 4;
  logic        clk_sys_i, rx_ready, tx_valid, tx_ready, res_err, rx_valid;
  logic        rst_i = 1'b1, stall = 1'b0, operational = 1'b1;
  logic [6:0]  node = 7'h05;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  tx_dlc;
  logic [63:0] rx_data, tx_data;
  logic [15:0] op_param = 16'h0000;
  logic [31:0] steps = 32'h0000_0800, total = 32'h0020_0000, pos_raw = 32'h0, position, exp_pos = 32'h0;
  logic [7:0]  tx_type = TXTYPE_ASYNC;
  logic [78:0] got;
  logic [78:0] exp_q[$];
  int          seed = 78568, n_mismatch = 0, num_checks = 0, n_cyc = 0, cyc = 0, last = 0, per_exp = 0;
  int          cyc_skip = 3, k;
  bit          ok;

  eps_top #(.CYC_PER_MS_P(CPM)) DUT (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .node_id_i      (node),
    .rx_valid_i     (rx_valid),
    .rx_ready_o     (rx_ready),
    .rx_id_i        (rx_id),
    .rx_data_i      (rx_data),
    .tx_valid_o     (tx_valid),
    .tx_ready_i     (tx_ready),
    .tx_id_o        (tx_id),
    .tx_dlc_o       (tx_dlc),
    .tx_data_o      (tx_data),
    .op_param_i     (op_param),
    .custom_steps_i (steps),
    .custom_total_i (total),
    .pos_raw_i      (pos_raw),
    .tx_type_i      (tx_type),
    .operational_i  (operational),
    .position_o     (position),
    .res_err_o      (res_err)
  );
  eps_master u_mst (
    .clk_sys_i  (clk_sys_i),
    .node_id_i  (node),
    .rx_ready_i (rx_ready),
    .stall_i    (stall),
    .rx_valid_o (rx_valid),
    .rx_id_o    (rx_id),
    .rx_data_o  (rx_data),
    .tx_ready_o (tx_ready)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [78:0] e, input logic [78:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [78:0] fr(input logic [10:0] b, input logic [3:0] l, input logic [63:0] d);
    return {b + 11'(node), l, d};
  endfunction
  task automatic req(input logic [7:0] c, input logic [15:0] i, input logic [31:0] v, input logic [78:0] e);
    exp_q.push_back(e);
    u_mst.send(c, i, v, 50, ok);
    chk("taken", 79'(1), 79'(ok));
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] i, input logic [31:0] v);
    req(c, i, v, fr(SDO_TX_BASE, DLC_FULL, {32'h0, SUB_0, i, CMD_WR_ACK}));
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] i, input logic [31:0] v);
    req(CMD_RD, i, 32'h0, fr(SDO_TX_BASE, DLC_FULL, {v, SUB_0, i, a}));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got = {tx_id, tx_dlc, tx_data};
      if (tx_id === PDO1_TX_BASE + 11'(node)) begin
        n_cyc++;
        chk("cyclic", fr(PDO1_TX_BASE, DLC_POS, {32'h0, exp_pos}), got);
        if (cyc_skip > 0)
          cyc_skip--;
        else
          chk("interval", 79'(per_exp), 79'(cyc - last));
        last = cyc;
      end else if (exp_q.size() == 0)
        chk("spare frame", 79'(0), got);
      else
        chk("answer", exp_q.pop_front(), got);
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i   <= 1'b0;
    pos_raw <= 32'($random(seed)) & 32'h00FF_FFFF;
    settle(4);
    chk("position", 79'(pos_raw), 79'(position));
    rd(CMD_RD_ANS16, IDX_CYCLIC, 32'h0);
    rd(CMD_RD_ANS32, IDX_PRESET, 32'h0);
    op_param <= 16'h0004;
    pos_raw  <= 32'h0000_7000;
    settle(4);
    chk("scaled", 79'(32'h0000_1C00), 79'(position));
    chk("res ok", 79'(0), 79'(res_err));
    total <= 32'h0000_0400;
    // keep the scaled read position inside the small total so one fold suffices
    pos_raw <= 32'h0000_0400;
    settle(3);
    chk("res bad", 79'(1), 79'(res_err));
    op_param <= 16'h0000;
    settle(3);
    chk("res off", 79'(0), 79'(res_err));
    total   <= 32'h0020_0000;
    // shaft still, fresh preset after scaling change
    pos_raw <= 32'($random(seed)) & 32'h00FF_FFFF;
    settle(2);
    wr(CMD_WR32, IDX_PRESET, 32'd1000);
    settle(4);
    chk("preset", 79'(32'd1000), 79'(position));
    pos_raw <= pos_raw + 32'd1;
    settle(4);
    chk("track", 79'(32'd1001), 79'(position));
    rd(CMD_RD_ANS32, IDX_PRESET, 32'd1000);
    rd(CMD_RD_ANS32, IDX_POSITION, 32'd1001);
    wr(CMD_WR32, IDX_PRESET, 32'h01FF_FFFF);
    pos_raw <= pos_raw + 32'd1;
    settle(4);
    chk("wrap", 79'(0), 79'(position));
    chk("idle timer", 79'(0), 79'(n_cyc));
    per_exp = 3 * CPM;
    wr(CMD_WR16, IDX_CYCLIC, {16'($random(seed)), 16'h0003});
    settle(80);
    chk("frames", 79'(1), 79'(n_cyc >= 5));
    cyc_skip = 3;
    per_exp  = 2 * CPM;
    wr(CMD_WR16, IDX_CYCLIC, 32'h0000_0002);
    settle(60);
    operational <= 1'b0;
    settle(6);
    k = n_cyc;
    settle(40);
    chk("stopped", 79'(k), 79'(n_cyc));
    rd(CMD_RD_ANS16, IDX_CYCLIC, 32'h0000_0002);
    cyc_skip = 3;
    operational <= 1'b1;
    wr(CMD_WR16, IDX_CYCLIC, 32'h0);
    settle(6);
    k = n_cyc;
    settle(40);
    chk("timer zero", 79'(k), 79'(n_cyc));
    // frames pile up while the master stalls, until requests are refused
    stall <= 1'b1;
    k = 0;
    ok = 1'b1;
    while (ok && k < 40) begin
      exp_q.push_back(fr(SDO_TX_BASE, DLC_FULL, {32'h0, SUB_0, IDX_CYCLIC, CMD_RD_ANS16}));
      u_mst.send(CMD_RD, IDX_CYCLIC, 32'h0, 20, ok);
      k++;
    end
    chk("refused", 79'(1), 79'(k >= 33 && k <= 36));
    stall <= 1'b0;
    u_mst.wait_take(100, ok);
    chk("late take", 79'(1), 79'(ok));
    for (k = 0; k < 500 && exp_q.size() > 0; k++)
      settle(1);
    chk("drained", 79'(0), 79'(exp_q.size()));
    complete_run();
  end

  initial begin
    #(4 * 20000);
    n_mismatch++;
    complete_run();
  end
endmodule
